// ---- hw/rbs_boot_seq.sv ----
// Reset and boot sequencer: hardware/scan reset pairing, boot modes, CPU stall.
// Assumes an AXI4-Lite host on aclk, pins asynchronous, ROM byte port on aclk.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "rbs_map.svh"
module rbs_boot_seq #(
  parameter int ROM_BYTES = `RBS_ROM_BYTES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        hw_reset_n,
  input  wire logic        scan_clock,
  input  wire logic        scan_reset_n,
  input  wire logic        scan_reset_driven,
  input  wire logic        emulation_config_pin_hi,
  input  wire logic        emulation_config_pin_lo,
  input  wire logic [1:0]  boot_mode_sel,
  input  wire logic        pci_select,
  input  wire logic        big_endian,
  input  wire logic        cpu_int_clear,
  output logic             cpu_reset,
  output logic             cpu_stall,
  output logic             cpu_interrupt,
  output logic             periph_reset,
  output logic             host_port_en,
  output logic             pci_port_en,
  output logic             id_variant_valid,
  output logic             emulation_reset,
  output logic             boundary_scan_mode,
  output logic             rom_req,
  output logic [9:0]       rom_addr,
  input  wire logic        rom_ack,
  input  wire logic [7:0]  rom_data
);
  localparam int WORDS = ROM_BYTES / 4;
  localparam int WA    = $clog2(WORDS);
  localparam int BA    = $clog2(ROM_BYTES);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic       pin_hw_n;
  logic       pin_sclk;
  logic       pin_srst_n;
  logic [1:0] pin_emu;
  logic [1:0] pin_mode;
  logic       pin_pci;
  logic       pin_endian;
  logic       pin_srst_raw;
  logic       pin_srst_drv;

  // Scan reset level and drive sense synchronised apart; gating raw pins could glitch
  rbs_sync #(.W(10)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({hw_reset_n, scan_clock, scan_reset_n, scan_reset_driven,
               emulation_config_pin_hi, emulation_config_pin_lo, boot_mode_sel, pci_select,
               big_endian}),
    .q       ({pin_hw_n, pin_sclk, pin_srst_raw, pin_srst_drv, pin_emu, pin_mode, pin_pci,
               pin_endian})
  );

  // Undriven scan reset pin reads low
  assign pin_srst_n = pin_srst_drv & pin_srst_raw;

  ////////////////////////////////////////////////////////////////////////////////
  // Boot memory and byte packer

  logic [31:0] mem [WORDS];
  rbs_pack_if  pk ();

  rbs_byte_packer u_pack (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pk      (pk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic          aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff, awready_ff, wready_ff;
  logic          arready_ff;
  logic [3:0]    aw_addr_ff;
  logic [31:0]   w_data_ff, rdata_ff;
  logic [3:0]    w_strb_ff;
  logic [1:0]    bresp_ff, rresp_ff;
  logic [WA-1:0] mem_addr_ff;
  logic          nxt_aw_full, nxt_w_full, nxt_bvalid, nxt_rvalid, nxt_awready, nxt_wready;
  logic          nxt_arready;
  logic [3:0]    nxt_aw_addr;
  logic [31:0]   nxt_w_data, nxt_rdata;
  logic [3:0]    nxt_w_strb;
  logic [1:0]    nxt_bresp, nxt_rresp;
  logic [WA-1:0] nxt_mem_addr;
  logic          do_write, do_read, mem_ok, host_mem_wr;
  logic [31:0]   status_word, ctrl_word;

  // Offset decode shared by reads and writes
  function automatic logic reg_hit(input logic [3:0] a);
    reg_hit = (a == `RBS_OFF_HOST_CTRL) || (a == `RBS_OFF_STATUS) ||
              (a == `RBS_OFF_MEM_ADDR) || (a == `RBS_OFF_MEM_DATA);
  endfunction

  // Byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
    merge = o;
  endfunction

  assign do_write    = aw_full_ff && w_full_ff && !bvalid_ff;
  assign do_read     = arvalid && arready_ff;
  assign host_mem_wr = do_write && (aw_addr_ff == `RBS_OFF_MEM_DATA) && mem_ok;

  // Channel handshakes, address window and read mux
  always_comb begin
    nxt_aw_addr  = aw_addr_ff;
    nxt_w_data   = w_data_ff;
    nxt_w_strb   = w_strb_ff;
    nxt_aw_full  = aw_full_ff;
    nxt_w_full   = w_full_ff;
    nxt_bvalid   = bvalid_ff;
    nxt_bresp    = bresp_ff;
    nxt_rvalid   = rvalid_ff;
    nxt_rresp    = rresp_ff;
    nxt_rdata    = rdata_ff;
    nxt_mem_addr = mem_addr_ff;
    if (awvalid && awready_ff) begin
      nxt_aw_full = 1'h1;
      nxt_aw_addr = awaddr;
    end
    if (wvalid && wready_ff) begin
      nxt_w_full = 1'h1;
      nxt_w_data = wdata;
      nxt_w_strb = wstrb;
    end
    if (bvalid_ff && bready) begin
      nxt_bvalid = 1'h0;
    end
    if (do_write) begin
      nxt_aw_full = 1'h0;
      nxt_w_full  = 1'h0;
      nxt_bvalid  = 1'h1;
      nxt_bresp   = reg_hit(aw_addr_ff) ? `RBS_RESP_OKAY : `RBS_RESP_SLVERR;
      if (aw_addr_ff == `RBS_OFF_MEM_ADDR) begin
        nxt_mem_addr = WA'(merge(32'(mem_addr_ff), w_data_ff, w_strb_ff));
      end
      if (host_mem_wr) begin
        nxt_mem_addr = mem_addr_ff + 1'h1;
      end
    end
    if (rvalid_ff && rready) begin
      nxt_rvalid = 1'h0;
    end
    if (do_read) begin
      nxt_rvalid = 1'h1;
      nxt_rresp  = reg_hit(araddr) ? `RBS_RESP_OKAY : `RBS_RESP_SLVERR;
      case (araddr)
        `RBS_OFF_HOST_CTRL: nxt_rdata = ctrl_word;
        `RBS_OFF_STATUS:    nxt_rdata = status_word;
        `RBS_OFF_MEM_ADDR:  nxt_rdata = 32'(mem_addr_ff);
        `RBS_OFF_MEM_DATA:  nxt_rdata = mem[mem_addr_ff];
        default:            nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_awready = !nxt_aw_full && !nxt_bvalid;
    nxt_wready  = !nxt_w_full && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff  <= 1'h0;
      w_full_ff   <= 1'h0;
      bvalid_ff   <= 1'h0;
      rvalid_ff   <= 1'h0;
      awready_ff  <= 1'h0;
      wready_ff   <= 1'h0;
      arready_ff  <= 1'h0;
      aw_addr_ff  <= 4'h0;
      w_data_ff   <= 32'h0000_0000;
      w_strb_ff   <= 4'h0;
      bresp_ff    <= `RBS_RESP_OKAY;
      rresp_ff    <= `RBS_RESP_OKAY;
      rdata_ff    <= 32'h0000_0000;
      mem_addr_ff <= '0;
    end else begin
      aw_full_ff  <= nxt_aw_full;
      w_full_ff   <= nxt_w_full;
      bvalid_ff   <= nxt_bvalid;
      rvalid_ff   <= nxt_rvalid;
      awready_ff  <= nxt_awready;
      wready_ff   <= nxt_wready;
      arready_ff  <= nxt_arready;
      aw_addr_ff  <= nxt_aw_addr;
      w_data_ff   <= nxt_w_data;
      w_strb_ff   <= nxt_w_strb;
      bresp_ff    <= nxt_bresp;
      rresp_ff    <= nxt_rresp;
      rdata_ff    <= nxt_rdata;
      mem_addr_ff <= nxt_mem_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Boot sequencing

  rbs_pkg::rbs_state_t st_ff, nxt_st;
  logic          hw_n_d_ff, running_ff, stall_ff, cpu_rst_ff, h2c_ff, cpu_int_ff;
  logic          pci_ff, endian_ff, copy_done_ff, req_ff;
  logic [1:0]    mode_ff;
  logic [BA-1:0] byte_ff;
  logic [WA-1:0] word_ff;
  logic          nxt_running, nxt_stall, nxt_cpu_rst, nxt_h2c, nxt_cpu_int, nxt_pci;
  logic          nxt_endian, nxt_copy_done, nxt_req;
  logic [1:0]    nxt_mode;
  logic [BA-1:0] nxt_byte;
  logic [WA-1:0] nxt_word;
  logic          h2c_wr, h2c_set;

  assign mem_ok  = running_ff && (st_ff != rbs_pkg::RBS_S_ROM_COPY);
  assign h2c_wr  = do_write && (aw_addr_ff == `RBS_OFF_HOST_CTRL) &&
                   w_strb_ff[`RBS_H2C_BIT / 8] && w_data_ff[`RBS_H2C_BIT] && running_ff;
  // Refused while the bit is still set, unless cleared now
  assign h2c_set = h2c_wr && (!h2c_ff || cpu_int_clear);

  // Reset hold, strap capture, mode dispatch, copy and release
  always_comb begin
    nxt_st        = st_ff;
    nxt_running   = running_ff;
    nxt_stall     = stall_ff;
    nxt_cpu_rst   = cpu_rst_ff;
    nxt_mode      = mode_ff;
    nxt_pci       = pci_ff;
    nxt_endian    = endian_ff;
    nxt_copy_done = copy_done_ff;
    nxt_req       = req_ff;
    nxt_byte      = byte_ff;
    nxt_word      = word_ff;
    nxt_cpu_int   = 1'h0;
    nxt_h2c       = h2c_set ? 1'h1 : (cpu_int_clear ? 1'h0 : h2c_ff);
    case (st_ff)
      rbs_pkg::RBS_S_RESET: begin
        nxt_stall   = 1'h0;
        nxt_cpu_rst = 1'h1;
        nxt_h2c     = 1'h0;
        if (pin_hw_n && !hw_n_d_ff) begin
          nxt_running = 1'h1;
          nxt_cpu_rst = 1'h0;
          nxt_mode    = pin_mode;
          nxt_pci     = pin_pci;
          nxt_endian  = pin_endian;
          nxt_byte    = '0;
          nxt_word    = '0;
          case (pin_mode)
            `RBS_BOOT_HOST: begin
              nxt_st    = rbs_pkg::RBS_S_HOST_STALL;
              nxt_stall = 1'h1;
            end
            `RBS_BOOT_ROM: begin
              nxt_st    = rbs_pkg::RBS_S_ROM_COPY;
              nxt_stall = 1'h1;
              nxt_req   = 1'h1;
            end
            default: nxt_st = rbs_pkg::RBS_S_RUN;
          endcase
        end
      end
      rbs_pkg::RBS_S_HOST_STALL: begin
        if (h2c_set) begin
          nxt_stall = 1'h0;
          nxt_st    = rbs_pkg::RBS_S_RUN;
        end
      end
      rbs_pkg::RBS_S_ROM_COPY: begin
        if (req_ff && rom_ack) begin
          nxt_byte = byte_ff + 1'h1;
          nxt_req  = (byte_ff != BA'(ROM_BYTES - 1));
        end
        if (pk.word_valid) begin
          nxt_word = word_ff + 1'h1;
          if (word_ff == WA'(WORDS - 1)) begin
            nxt_stall     = 1'h0;
            nxt_copy_done = 1'h1;
            nxt_st        = rbs_pkg::RBS_S_RUN;
          end
        end
      end
      rbs_pkg::RBS_S_RUN: begin
        nxt_cpu_int = h2c_set;
      end
      default: nxt_st = rbs_pkg::RBS_S_RESET;
    endcase
    if (!pin_hw_n) begin
      nxt_st        = rbs_pkg::RBS_S_RESET;
      nxt_running   = 1'h0;
      nxt_stall     = 1'h0;
      nxt_cpu_rst   = 1'h1;
      nxt_req       = 1'h0;
      nxt_copy_done = 1'h0;
      nxt_cpu_int   = 1'h0;
      nxt_h2c       = 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff        <= rbs_pkg::RBS_S_RESET;
      hw_n_d_ff    <= 1'h0;
      running_ff   <= 1'h0;
      stall_ff     <= 1'h0;
      cpu_rst_ff   <= 1'h1;
      h2c_ff       <= 1'h0;
      cpu_int_ff   <= 1'h0;
      mode_ff      <= `RBS_BOOT_NONE;
      pci_ff       <= 1'h0;
      endian_ff    <= 1'h0;
      copy_done_ff <= 1'h0;
      req_ff       <= 1'h0;
      byte_ff      <= '0;
      word_ff      <= '0;
    end else begin
      st_ff        <= nxt_st;
      hw_n_d_ff    <= pin_hw_n;
      running_ff   <= nxt_running;
      stall_ff     <= nxt_stall;
      cpu_rst_ff   <= nxt_cpu_rst;
      h2c_ff       <= nxt_h2c;
      cpu_int_ff   <= nxt_cpu_int;
      mode_ff      <= nxt_mode;
      pci_ff       <= nxt_pci;
      endian_ff    <= nxt_endian;
      copy_done_ff <= nxt_copy_done;
      req_ff       <= nxt_req;
      byte_ff      <= nxt_byte;
      word_ff      <= nxt_word;
    end
  end

  // Copied bytes to packer
  assign pk.byte_valid = req_ff && rom_ack && (st_ff == rbs_pkg::RBS_S_ROM_COPY);
  assign pk.byte_data  = rom_data;
  assign pk.big_endian = endian_ff;
  assign pk.clear      = (st_ff == rbs_pkg::RBS_S_RESET);

  // Boot memory writes from host or copy
  always_ff @(posedge aclk) begin
    if (host_mem_wr) begin
      mem[mem_addr_ff] <= merge(mem[mem_addr_ff], w_data_ff, w_strb_ff);
    end else if (pk.word_valid && (st_ff == rbs_pkg::RBS_S_ROM_COPY)) begin
      mem[word_ff] <= pk.word_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scan reset and emulation configuration

  logic       sclk_d_ff, srst_d_ff, emu_rst_ff, emu_valid_ff;
  logic [1:0] emu_ff;
  logic       nxt_emu_rst, nxt_emu_valid;
  logic [1:0] nxt_emu;

  // Scan reset acts on scan clock rises; its rise latches the pins while running
  always_comb begin
    nxt_emu_rst   = emu_rst_ff;
    nxt_emu       = emu_ff;
    nxt_emu_valid = emu_valid_ff;
    if (pin_sclk && !sclk_d_ff) begin
      nxt_emu_rst = !pin_srst_n;
    end
    if (pin_srst_n && !srst_d_ff && running_ff) begin
      nxt_emu       = pin_emu;
      nxt_emu_valid = 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_d_ff    <= 1'h0;
      srst_d_ff    <= 1'h0;
      emu_rst_ff   <= 1'h1;
      emu_ff       <= 2'h0;
      emu_valid_ff <= 1'h0;
    end else begin
      sclk_d_ff    <= pin_sclk;
      srst_d_ff    <= pin_srst_n;
      emu_rst_ff   <= nxt_emu_rst;
      emu_ff       <= nxt_emu;
      emu_valid_ff <= nxt_emu_valid;
    end
  end

  logic hport_ff;
  logic pport_ff;
  logic boundary_scan_logic_ff;
  logic nxt_hport;
  logic nxt_pport;
  logic nxt_boundary_scan_logic;

  // Port enables and scan mode from next state, so the outputs leave flops
  always_comb begin
    nxt_hport = nxt_running && (nxt_mode == `RBS_BOOT_HOST) && !nxt_pci;
    nxt_pport = nxt_running && (nxt_mode == `RBS_BOOT_HOST) && nxt_pci;
    nxt_boundary_scan_logic = nxt_emu_valid && (nxt_emu == `RBS_EMU_BOUNDARY_SCAN_LOGIC);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hport_ff <= 1'h0;
      pport_ff <= 1'h0;
      boundary_scan_logic_ff <= 1'h0;
    end else begin
      hport_ff <= nxt_hport;
      pport_ff <= nxt_pport;
      boundary_scan_logic_ff <= nxt_boundary_scan_logic;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status words and outputs

  always_comb begin
    ctrl_word                        = 32'h0000_0000;
    ctrl_word[`RBS_H2C_BIT]          = h2c_ff;
    status_word                      = 32'h0000_0000;
    status_word[`RBS_ST_STALL]       = stall_ff;
    status_word[`RBS_ST_RUNNING]     = running_ff;
    status_word[`RBS_ST_MODE_HI:`RBS_ST_MODE_LO] = mode_ff;
    status_word[`RBS_ST_PCI]         = pci_ff;
    status_word[`RBS_ST_ENDIAN]      = endian_ff;
    status_word[`RBS_ST_EMU_HI:`RBS_ST_EMU_LO] = emu_ff;
    status_word[`RBS_ST_EMU_VALID]   = emu_valid_ff;
    status_word[`RBS_ST_EMU_RESET]   = emu_rst_ff;
    status_word[`RBS_ST_COPY_DONE]   = copy_done_ff;
  end

  assign awready            = awready_ff;
  assign wready             = wready_ff;
  assign bresp              = bresp_ff;
  assign bvalid             = bvalid_ff;
  assign arready            = arready_ff;
  assign rdata              = rdata_ff;
  assign rresp              = rresp_ff;
  assign rvalid             = rvalid_ff;
  assign cpu_reset          = cpu_rst_ff;
  assign cpu_stall          = stall_ff;
  assign cpu_interrupt      = cpu_int_ff;
  assign periph_reset       = cpu_rst_ff;
  assign host_port_en       = hport_ff;
  assign pci_port_en        = pport_ff;
  assign id_variant_valid   = running_ff;
  assign emulation_reset    = emu_rst_ff;
  assign boundary_scan_mode = boundary_scan_logic_ff;
  assign rom_req            = req_ff;
  assign rom_addr           = 10'(byte_ff);
endmodule
`default_nettype wire

// ---- shared/rbs_map.svh ----
// Register offsets, field positions and codes of the reset/boot sequencer.
// Assumes inclusion by bare name from design files.
`ifndef RBS_MAP_SVH
`define RBS_MAP_SVH

// Register byte offsets on the AXI4-Lite port
`define RBS_OFF_HOST_CTRL  4'h0
`define RBS_OFF_STATUS     4'h4
`define RBS_OFF_MEM_ADDR   4'h8
`define RBS_OFF_MEM_DATA   4'hC

// Host port control register fields
`define RBS_H2C_BIT        0

// Status register fields
`define RBS_ST_STALL       0
`define RBS_ST_RUNNING     1
`define RBS_ST_MODE_LO     2
`define RBS_ST_MODE_HI     3
`define RBS_ST_PCI         4
`define RBS_ST_ENDIAN      5
`define RBS_ST_EMU_LO      6
`define RBS_ST_EMU_HI      7
`define RBS_ST_EMU_VALID   8
`define RBS_ST_EMU_RESET   9
`define RBS_ST_COPY_DONE   10

// Boot mode strap codes
`define RBS_BOOT_NONE      2'h0
`define RBS_BOOT_HOST      2'h1
`define RBS_BOOT_ROM       2'h2

// Emulation configuration code for boundary scan mode
`define RBS_EMU_BOUNDARY_SCAN_LOGIC      2'h0

// AXI responses
`define RBS_RESP_OKAY      2'h0
`define RBS_RESP_SLVERR    2'h2

// Boot image size and start address
`define RBS_ROM_BYTES      1024
`define RBS_BOOT_ADDR      32'h0000_0000

`endif

// ---- shared/rbs_pkg.sv ----
// Types shared by the reset/boot sequencer modules.
// Assumes nothing of its surroundings.
package rbs_pkg;
  typedef enum logic [1:0] {
    RBS_S_RESET,
    RBS_S_HOST_STALL,
    RBS_S_ROM_COPY,
    RBS_S_RUN
  } rbs_state_t;
endpackage

// ---- shared/rbs_pack_if.sv ----
// Byte-to-word link between boot sequencer and byte packer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface rbs_pack_if;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic        big_endian;
  logic        clear;
  logic        word_valid;
  logic [31:0] word_data;

  modport src    (output byte_valid, output byte_data, output big_endian, output clear,
                  input word_valid, input word_data);
  modport packer (input byte_valid, input byte_data, input big_endian, input clear,
                  output word_valid, output word_data);
endinterface
`default_nettype wire

// ---- hw/rbs_sync.sv ----
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module rbs_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // First stage feeds only the second
  always_comb begin
    nxt_meta = d;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// ---- hw/rbs_byte_packer.sv ----
// Packs four consecutive bytes into one 32-bit word in the chosen byte order.
// Assumes one byte at most per cycle on the same clock.
`timescale 1ns/100ps
`default_nettype none
module rbs_byte_packer (
  input  wire logic aclk,
  input  wire logic aresetn,
  rbs_pack_if.packer pk
);
  logic [1:0]  cnt_ff;
  logic [31:0] word_ff;
  logic        vld_ff;
  logic [1:0]  nxt_cnt;
  logic [31:0] nxt_word;
  logic        nxt_vld;

  // Byte lane placement per endian order
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_word = word_ff;
    nxt_vld  = 1'h0;
    if (pk.clear) begin
      nxt_cnt = 2'h0;
    end else if (pk.byte_valid) begin
      if (pk.big_endian) begin
        nxt_word = {word_ff[23:0], pk.byte_data};
      end else begin
        nxt_word = {pk.byte_data, word_ff[31:8]};
      end
      nxt_cnt = cnt_ff + 2'h1;
      nxt_vld = (cnt_ff == 2'h3);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= 2'h0;
      word_ff <= 32'h0000_0000;
      vld_ff  <= 1'h0;
    end else begin
      cnt_ff  <= nxt_cnt;
      word_ff <= nxt_word;
      vld_ff  <= nxt_vld;
    end
  end

  assign pk.word_valid = vld_ff;
  assign pk.word_data  = word_ff;
endmodule
`default_nettype wire

// ---- verification/rbs_boot_seq_assertions.sv ----
// Port checker of the reset/boot sequencer.
// Assumes a bind onto rbs_boot_seq, one clock.
`timescale 1ns/100ps
`default_nettype none
module rbs_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       hw_reset_n,
  input wire logic       cpu_reset,
  input wire logic       cpu_stall,
  input wire logic       cpu_interrupt,
  input wire logic       host_port_en,
  input wire logic       pci_port_en,
  input wire logic       id_variant_valid,
  input wire logic       rom_req,
  input wire logic       rom_ack,
  input wire logic [9:0] rom_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  held_rst_a: assert property (!hw_reset_n [*4] |-> cpu_reset)
    else $error("core not held");
  rst_stall_a: assert property (cpu_reset |-> !cpu_stall)
    else $error("stall in reset");
  id_valid_a: assert property ($rose(id_variant_valid) |-> !cpu_reset)
    else $error("id early");
  rom_step_a: assert property (rom_req && rom_ack |=>
    !rom_req || rom_addr == $past(rom_addr) + 10'h001) else $error("rom step");
  rom_hold_a: assert property (rom_req && !rom_ack |=> !rom_req || $stable(rom_addr))
    else $error("rom moved");
  rom_stall_a: assert property (rom_req |-> cpu_stall)
    else $error("copy unstalled");
  irq_stall_a: assert property (cpu_stall |-> !cpu_interrupt)
    else $error("irq in stall");
  irq_pulse_a: assert property (cpu_interrupt |=> !cpu_interrupt)
    else $error("irq long");
  port_excl_a: assert property (!(host_port_en && pci_port_en))
    else $error("two ports");
  // Main scenarios reached
  cover property (rom_req && rom_ack);
  cover property ($fell(cpu_stall));
  cover property (cpu_interrupt);
endmodule
bind rbs_boot_seq rbs_chk i_chk (.aclk, .aresetn, .hw_reset_n, .cpu_reset, .cpu_stall,
  .cpu_interrupt, .host_port_en, .pci_port_en, .id_variant_valid, .rom_req, .rom_ack,
  .rom_addr);
`default_nettype wire

// ---- verification/rbs_rom_model.sv ----
// Boot ROM on region one: byte a holds a ^ 8'ha5.
// Assumes the byte port on aclk; slow acks one cycle in four.
`timescale 1ns/100ps
`default_nettype none
module rbs_rom_model (
  input  wire logic       aclk,
  input  wire logic       rom_req,
  input  wire logic [9:0] rom_addr,
  input  wire logic       slow,
  output logic            rom_ack,
  output logic [7:0]      rom_data
);
  logic [1:0] tick_ff = 2'h0;
  // Ack prompt or every fourth cycle
  always_ff @(posedge aclk) begin
    tick_ff <= tick_ff + 2'h1;
    rom_ack <= rom_req && (!slow || tick_ff == 2'h3);
  end
  // Bytes stored in system order; inverse shown when not acked
  assign rom_data = rom_ack ? (rom_addr[7:0] ^ 8'ha5) : ~(rom_addr[7:0] ^ 8'ha5);
endmodule
`default_nettype wire

// ---- verification/rbs_boot_seq_tb_top.sv ----
// Self-checking bench of the reset/boot sequencer.
// Assumes the ROM model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module rbs_boot_seq_tb_top;
  localparam int RB = 16;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic hw_reset_n = 0, scan_clock = 0, scan_reset_n = 0, scan_reset_driven = 1;
  logic emulation_config_pin_hi = 0, emulation_config_pin_lo = 0, pci_select = 0;
  logic big_endian = 0, cpu_int_clear = 0, slow = 0;
  logic [1:0] boot_mode_sel = 0, bresp, rresp, br;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
  logic [31:0] wdata = 0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, rom_ack, rom_req, cpu_reset, cpu_stall;
  logic cpu_interrupt, periph_reset, host_port_en, pci_port_en, id_variant_valid;
  logic emulation_reset, boundary_scan_mode;
  logic [9:0] rom_addr;
  logic [7:0] rom_data;
  int n_mismatch = 0, compares = 0, n_irq = 0, cyc = 0;
  rbs_boot_seq #(.ROM_BYTES(RB)) i_dut (.*);
  rbs_rom_model i_rom (.aclk, .rom_req, .rom_addr, .slow, .rom_ack, .rom_data);
  initial forever #5 aclk = ~aclk;
  // Scan clock keeps running, also under scan reset
  always @(posedge aclk) if (cyc % 3 == 0) scan_clock <= ~scan_clock;
  // Cycle count, interrupt count, hang limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    n_irq <= n_irq + int'(cpu_interrupt === 1'b1);
    if (cyc == 20000) begin n_mismatch++; close_out(); end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] e, s, input string nm);
    compares++;
    if (s !== e) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, s); end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    br = bresp; bready <= 0;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin @(posedge aclk); if (arready) arvalid <= 0; end while (!rvalid);
    rd = rdata; rready <= 0;
    chk(0, rresp, "rresp");
  endtask
  task automatic boot(input logic [1:0] m, input logic p, e);
    @(posedge aclk);
    hw_reset_n <= 0; boot_mode_sel <= m; pci_select <= p; big_endian <= e;
    repeat (6) @(posedge aclk);
    hw_reset_n <= 1;
    repeat (6) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_none(input logic [1:0] m);
    boot(m, 0, 0);
    chk(0, cpu_stall, "stall");
    chk(0, cpu_reset, "cpu_reset");
    chk(1, id_variant_valid, "id_valid");
    $display("none %0d done", m);
  endtask
  task automatic t_host(input logic p);
    int k;
    boot(1, p, 0);
    chk(1, cpu_stall, "stall");
    chk({!p, p}, {host_port_en, pci_port_en}, "ports");
    chk(0, periph_reset, "periph_reset");
    pci_select <= !p;
    repeat (4) @(posedge aclk);
    chk({!p, p}, {host_port_en, pci_port_en}, "ports held");
    axw(4'h8, 3); axw(4'hc, 32'hc0de_0042); axw(4'h8, 3); axr(4'hc);
    chk(32'hc0de_0042, rd, "mem");
    axw(4'h2, 1); chk(2, br, "unmapped");
    k = n_irq;
    axw(4'h0, 1); repeat (2) @(posedge aclk);
    chk(0, cpu_stall, "release");
    chk(k, n_irq, "stall irq");
    axw(4'h0, 1); repeat (2) @(posedge aclk);
    chk(k, n_irq, "blocked");
    cpu_int_clear <= 1; @(posedge aclk); cpu_int_clear <= 0;
    axw(4'h0, 1); repeat (2) @(posedge aclk);
    chk(k + 1, n_irq, "irq");
    $display("host %0d done", p);
  endtask
  task automatic t_rom(input logic e, s);
    logic [31:0] w;
    slow <= s;
    boot(2, 0, e);
    chk(1, cpu_stall, "stall");
    while (cpu_stall) @(posedge aclk);
    for (int i = 0; i < RB / 4; i++) begin
      for (int k = 0; k < 4; k++) w[8*k +: 8] = 8'(4 * i + (e ? 3 - k : k)) ^ 8'ha5;
      axw(4'h8, i); axr(4'hc);
      chk(w, rd, "rom word");
    end
    axr(4'h4); chk(1, rd[10], "copy done");
    $display("rom %0d done", e);
  endtask
  task automatic t_scan;
    boot(0, 0, 0);
    emulation_config_pin_lo <= 1; scan_reset_n <= 1; scan_reset_driven <= 0;
    repeat (20) @(posedge aclk);
    chk(1, emulation_reset, "pulled low");
    scan_reset_driven <= 1;
    repeat (20) @(posedge aclk);
    chk(0, emulation_reset, "emu run");
    chk(0, boundary_scan_mode, "scan mode");
    axr(4'h4); chk(3'b101, rd[8:6], "emu code");
    scan_reset_n <= 0; emulation_config_pin_lo <= 0;
    repeat (20) @(posedge aclk);
    chk(1, emulation_reset, "emu held");
    scan_reset_n <= 1;
    repeat (20) @(posedge aclk);
    chk(1, boundary_scan_mode, "scan mode on");
    $display("scan done");
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    t_none(0); t_none(3); t_host(0); t_host(1); t_rom(0, 0); t_rom(1, 1); t_scan;
    close_out();
  end
endmodule
`default_nettype wire
